// *** idio_pkg.sv ***
package idio_pkg;
  // ****************************************
  // register offsets within the byte window
  // ****************************************
  localparam logic [2:0] OFF_IN_LOW = 3'h0;
  localparam logic [2:0] OFF_IN_HIGH = 3'h1;
  localparam logic [2:0] OFF_LATCH_CTRL = 3'h3;
  localparam logic [2:0] OFF_RELAY_LOW = 3'h4;
  localparam logic [2:0] OFF_RELAY_HIGH = 3'h5;
  // ****************************************
  // latching control fields and resets
  // ****************************************
  localparam int LC_LATCH_EN_BIT = 0;
  localparam int LC_NOTIFY_EN_BIT = 1;
  localparam int LC_EDGE_FALL_BIT = 2;
  localparam int LC_REQ_BIT = 7;
  localparam logic [7:0] LC_WR_MASK = 8'h07;
  localparam logic [7:0] LC_RESET = 8'h00;
  localparam logic [7:0] RELAY_RESET = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;
  localparam int PORT_BITS = 8;
endpackage
`default_nettype wire

// *** idio_sync.sv ***
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// two-flop synchroniser, one per bit
// ****************************************
module idio_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;
endmodule // idio_sync
`default_nettype wire

// *** idio_port.sv ***
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - base variant has eight inputs and eight relay outputs, one bit each.
// - offset 0 reads live input state, or captured state in latch mode; writes there do nothing.
// - wide variant reads inputs 0-7 at offset 0, inputs 8-15 at 1.
// - relay bytes read/write at offset 4, and 5 on wide variant.
// - latching control at offset 3 is readable and writable.
// - latch mode: active trigger edge captures inputs; port reads return them.
// - notify mode: trigger edge raises host interrupt request.
// - wide variant: each connector carries one input and one output byte.
module idio_port #(
  parameter int WIDE = 0
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [2:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic [7:0] in_lines_low,
  input wire logic [7:0] in_lines_high,
  input wire logic ext_trigger,
  output logic [7:0] relay_low,
  output logic [7:0] relay_high,
  output logic host_irq
);
  // ****************************************
  // input synchronisers
  // ****************************************
  logic [16:0] raw_in;
  logic [16:0] sync_in;
  logic [7:0] live_low;
  logic [7:0] live_high;
  logic trig_s;

  assign raw_in = {ext_trigger, in_lines_high, in_lines_low};

  idio_sync #(.WIDTH(17)) u_sync (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .async_in(raw_in),
    .sync_out(sync_in)
  );

  assign live_low = sync_in[7:0];
  assign live_high = (WIDE != 0) ? sync_in[15:8] : 8'h00;
  assign trig_s = sync_in[16];

  // ****************************************
  // register state
  // ****************************************
  logic [7:0] ctrl_q, ctrl_d;
  logic [7:0] relay_low_q, relay_low_d;
  logic [7:0] relay_high_q, relay_high_d;
  logic [7:0] hold_low_q, hold_low_d;
  logic [7:0] hold_high_q, hold_high_d;
  logic trig_prev_q, trig_prev_d;
  logic req_q, req_d;
  logic [7:0] rdata_q, rdata_d;
  logic edge_hit;
  logic latch_en;
  logic notify_en;
  logic [7:0] rd_val;

  assign latch_en = ctrl_q[idio_pkg::LC_LATCH_EN_BIT];
  assign notify_en = ctrl_q[idio_pkg::LC_NOTIFY_EN_BIT];

  // selected active edge of the trigger
  always_comb begin
    if (ctrl_q[idio_pkg::LC_EDGE_FALL_BIT]) begin
      edge_hit = trig_prev_q && !trig_s;
    end else begin
      edge_hit = !trig_prev_q && trig_s;
    end
  end

  // ****************************************
  // read mux
  // ****************************************
  always_comb begin
    rd_val = idio_pkg::READ_ZERO;
    if (reg_addr == idio_pkg::OFF_IN_LOW) begin
      rd_val = latch_en ? hold_low_q : live_low;
    end else if (reg_addr == idio_pkg::OFF_IN_HIGH && WIDE != 0) begin
      rd_val = latch_en ? hold_high_q : live_high;
    end else if (reg_addr == idio_pkg::OFF_LATCH_CTRL) begin
      rd_val = ctrl_q;
      rd_val[idio_pkg::LC_REQ_BIT] = req_q;
    end else if (reg_addr == idio_pkg::OFF_RELAY_LOW) begin
      rd_val = relay_low_q;
    end else if (reg_addr == idio_pkg::OFF_RELAY_HIGH && WIDE != 0) begin
      rd_val = relay_high_q;
    end
  end

  // ****************************************
  // next-state logic
  // ****************************************
  always_comb begin
    ctrl_d = ctrl_q;
    relay_low_d = relay_low_q;
    relay_high_d = relay_high_q;
    hold_low_d = hold_low_q;
    hold_high_d = hold_high_q;
    trig_prev_d = trig_s;
    req_d = req_q;
    rdata_d = rdata_q;
    if (reg_rd) begin
      rdata_d = rd_val;
    end
    if (reg_wr) begin
      if (reg_addr == idio_pkg::OFF_LATCH_CTRL) begin
        ctrl_d = reg_wdata & idio_pkg::LC_WR_MASK;
        if (reg_wdata[idio_pkg::LC_REQ_BIT]) begin
          req_d = 1'b0;
        end
      end else if (reg_addr == idio_pkg::OFF_RELAY_LOW) begin
        relay_low_d = reg_wdata;
      end else if (reg_addr == idio_pkg::OFF_RELAY_HIGH && WIDE != 0) begin
        relay_high_d = reg_wdata;
      end
    end
    if (edge_hit && latch_en) begin
      hold_low_d = live_low;
      hold_high_d = live_high;
    end
    if (edge_hit && notify_en) begin
      req_d = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q <= idio_pkg::LC_RESET;
      relay_low_q <= idio_pkg::RELAY_RESET;
      relay_high_q <= idio_pkg::RELAY_RESET;
      hold_low_q <= 8'h00;
      hold_high_q <= 8'h00;
      trig_prev_q <= 1'b0;
      req_q <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      ctrl_q <= ctrl_d;
      relay_low_q <= relay_low_d;
      relay_high_q <= relay_high_d;
      hold_low_q <= hold_low_d;
      hold_high_q <= hold_high_d;
      trig_prev_q <= trig_prev_d;
      req_q <= req_d;
      rdata_q <= rdata_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign relay_low = relay_low_q;
  assign relay_high = relay_high_q;
  assign host_irq = req_q;
  assign reg_rdata = rdata_q;
endmodule // idio_port
`default_nettype wire

// *** idio_props.sv ***
`timescale 1ns/10ps
`default_nettype none
// ****
// port register checks
// ****
module idio_props #(
  parameter int WIDE = 0
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [2:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] relay_low,
  input wire logic [7:0] relay_high,
  input wire logic host_irq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  relay_set_a: assert property (reg_wr && reg_addr == 3'h4
    |=> relay_low == $past(reg_wdata)) else $error("relay low lost");
  relay_keep_a: assert property (!(reg_wr && reg_addr == 3'h4)
    |=> $stable(relay_low)) else $error("relay low moved");
  high_set_a: assert property (reg_wr && reg_addr == 3'h5
    |=> relay_high == (WIDE ? $past(reg_wdata) : 8'h00))
    else $error("relay high wrong");
  relay_rb_a: assert property (reg_rd && reg_addr == 3'h4
    |=> reg_rdata == $past(relay_low)) else $error("relay readback");
  hole_zero_a: assert property (reg_rd && reg_addr inside {3'h2, 3'h6,
    3'h7} |=> reg_rdata == 8'h00) else $error("hole not zero");
  rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved");
  irq_clear_a: assert property ($fell(host_irq) |-> $past(reg_wr &&
    reg_addr == 3'h3 && reg_wdata[7])) else $error("irq dropped");
  ctrl_rb_a: assert property (reg_wr && reg_addr == 3'h3 ##1 reg_rd &&
    reg_addr == 3'h3 |=> reg_rdata[2:0] == $past(reg_wdata[2:0], 2))
    else $error("control readback");
endmodule // idio_props
bind idio_port idio_props #(.WIDE(WIDE)) u_props (.*);
`default_nettype wire

// *** idio_host.sv ***
`timescale 1ns/10ps
`default_nettype none
// ****
// host register access model
// ****
module idio_host (
  input wire logic clk_sys,
  output logic [2:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  initial {reg_addr, reg_wr, reg_rd, reg_wdata} = 13'h0000;
  // offsets only, base already located
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #1 {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
    @(posedge clk_sys);
    #1 {reg_addr, reg_wdata, reg_wr} = {~a, ~d, 1'b0};
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    #1 {reg_addr, reg_rd} = {a, 1'b1};
    @(posedge clk_sys);
    #1 {reg_addr, reg_rd} = {~a, 1'b0};
    d = reg_rdata;
  endtask
endmodule // idio_host
`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
// ****
// port register testbench
// ****
module tb_top;
  logic clk_sys, arst_n, ext_trigger, reg_wr, reg_rd, host_irq;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, in_lines_low, in_lines_high, d;
  logic [7:0] relay_low, relay_high;
  int mismatches = 0;
  int tests_run = 0;
  idio_port #(.WIDE(1)) dut (.*);
  idio_host h (.*);
  task automatic chk(input string n, input logic [7:0] e, s);
    tests_run++;
    if (s !== e) begin
      mismatches++;
      $display("[FAIL] %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic rchk(input logic [2:0] a, input logic [7:0] e);
    h.rd(a, d);
    chk("read", e, d);
  endtask
  task automatic t_relay;
    chk("relay rst", 8'h00, relay_low | relay_high);
    h.wr(3'h4, 8'hA5);
    chk("relay low", 8'hA5, relay_low);
    h.wr(3'h5, 8'h3C);
    chk("relay high", 8'h3C, relay_high);
    rchk(3'h4, 8'hA5);
    rchk(3'h5, 8'h3C);
  endtask
  task automatic t_holes;
    foreach (d[i]) if (!(i inside {3, 4, 5})) h.wr(i[2:0], 8'hFF);
    chk("relays kept", 8'hA5, relay_low);
    chk("relays high kept", 8'h3C, relay_high);
    rchk(3'h2, 8'h00);
    rchk(3'h6, 8'h00);
    rchk(3'h7, 8'h00);
    rchk(3'h0, 8'h5A);
    rchk(3'h1, 8'hC3);
  endtask
  task automatic t_events;
    h.wr(3'h3, 8'h01);
    ext_trigger = 1'b1;
    repeat (6) @(posedge clk_sys);
    #1 in_lines_low = 8'h0F;
    repeat (4) @(posedge clk_sys);
    rchk(3'h0, 8'h5A);
    rchk(3'h3, 8'h01);
    h.wr(3'h3, 8'h02);
    ext_trigger = 1'b0;
    repeat (6) @(posedge clk_sys);
    chk("irq fall", 8'h00, {7'h00, host_irq});
    #1 ext_trigger = 1'b1;
    repeat (6) @(posedge clk_sys);
    chk("irq rise", 8'h01, {7'h00, host_irq});
    rchk(3'h3, 8'h82);
    h.wr(3'h3, 8'h82);
    chk("irq clr", 8'h00, {7'h00, host_irq});
    rchk(3'h0, 8'h0F);
    h.wr(3'h3, 8'h06);
    ext_trigger = 1'b0;
    repeat (6) @(posedge clk_sys);
    chk("irq fall sel", 8'h01, {7'h00, host_irq});
  endtask
  task automatic print_verdict;
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    #20000;
    mismatches++;
    print_verdict();
  end
  initial begin
    {arst_n, ext_trigger, in_lines_low, in_lines_high} = 18'h05AC3;
    repeat (10) @(posedge clk_sys);
    #1 arst_n = 1'b1;
    t_relay();
    t_holes();
    t_events();
    print_verdict();
  end
endmodule // tb_top
`default_nettype wire
